// ==== hw/pgd_pkg.sv ====
// Purpose: shared constants and types of the planar graphics datapath
// Assumes: four 8-bit display planes, 20-bit host memory address
// Notes:   every index, field position and register port reset value is named here once
package pgd_pkg;

    // ------------
    // register indices behind the data port
    // ------------
    localparam logic [3:0] IDX_SET_RESET = 4'h0;
    localparam logic [3:0] IDX_SR_ENABLE = 4'h1;
    localparam logic [3:0] IDX_COLOR_CMP = 4'h2;
    localparam logic [3:0] IDX_ROTATE_OP = 4'h3;
    localparam logic [3:0] IDX_READ_SEL = 4'h4;
    localparam logic [3:0] IDX_ACCESS_MODE = 4'h5;
    localparam logic [3:0] IDX_WINDOW_CTL = 4'h6;
    localparam logic [3:0] IDX_PARTICIPATE = 4'h7;
    localparam logic [3:0] IDX_BIT_MASK = 4'h8;

    // ------------
    // field positions
    // ------------
    localparam int ROT_CNT_LSB = 0;
    localparam int ROT_OP_LSB = 3;
    localparam int MODE_WR_LSB = 0;
    localparam int MODE_READ_TYPE = 3;
    localparam int MODE_ODD_EVEN = 4;
    localparam int MODE_INTERLEAVE = 5;
    localparam int MODE_256 = 6;
    localparam int WIN_GRAPHICS = 0;
    localparam int WIN_CHAIN = 1;
    localparam int WIN_SEL_LSB = 2;

    // ------------
    // reset values
    // ------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_BIT_MASK = 8'hff;
    localparam logic [7:0] RST_PARTICIPATE = 8'h0f;

    // ------------
    // encodings
    // ------------
    localparam logic [1:0] WM_HOST = 2'h0;
    localparam logic [1:0] WM_LATCH = 2'h1;
    localparam logic [1:0] WM_FILL = 2'h2;
    localparam logic [1:0] WM_SR_MASK = 2'h3;
    localparam logic [1:0] OP_PASS = 2'h0;
    localparam logic [1:0] OP_AND = 2'h1;
    localparam logic [1:0] OP_OR = 2'h2;
    localparam logic [1:0] OP_XOR = 2'h3;

    // window base address tags
    localparam logic [2:0] WIN_128K_TAG = 3'h5;
    localparam logic [3:0] WIN_64K_TAG = 4'ha;
    localparam logic [4:0] WIN_B0_TAG = 5'h16;
    localparam logic [4:0] WIN_B8_TAG = 5'h17;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD_ISSUE,
        ST_RD_CAPTURE
    } pgd_state_t;

endpackage

// ==== hw/pgd_wr_if.sv ====
// Purpose: carries write datapath controls and results between modules
// Assumes: one clock domain, purely combinational exchange
// Notes:   ctrl drives the operands, wpath returns the plane data
`timescale 1ns/100ps
interface pgd_wr_if;
    logic [3:0] set_reset;
    logic [3:0] sr_enable;
    logic [2:0] rot_cnt;
    logic [1:0] logic_op;
    logic [1:0] write_mode;
    logic [7:0] bit_mask;
    logic [7:0] host_data;
    logic [31:0] latch;
    logic [31:0] plane_data;

    modport ctrl (
        output set_reset, sr_enable, rot_cnt, logic_op, write_mode, bit_mask,
        output host_data, latch,
        input plane_data
    );
    modport wpath (
        input set_reset, sr_enable, rot_cnt, logic_op, write_mode, bit_mask,
        input host_data, latch,
        output plane_data
    );
endinterface

// ==== hw/pgd_write_path.sv ====
// Purpose: combinational write datapath for the four planes
// Assumes: latch holds plane 0 in bits 7:0 up to plane 3 in bits 31:24
// Notes:   result is ready in the same cycle as its operands
`timescale 1ns/100ps
module pgd_write_path
    import pgd_pkg::*;
(
    pgd_wr_if.wpath wr
);

    // circular right rotation within the byte
    function automatic logic [7:0] rot_right(input logic [7:0] d, input logic [2:0] n);
        logic [15:0] twice;
        twice = {d, d} >> n;
        return twice[7:0];
    endfunction

    // combine source byte with latched byte
    function automatic logic [7:0] alu(input logic [1:0] op, input logic [7:0] s,
                                       input logic [7:0] l);
        case (op)
            OP_AND: return s & l;
            OP_OR: return s | l;
            OP_XOR: return s ^ l;
            default: return s;
        endcase
    endfunction

    // ------------
    // shared terms
    // ------------
    wire [7:0] rotated = rot_right(wr.host_data, wr.rot_cnt);
    wire [7:0] eff_mask = (wr.write_mode == WM_SR_MASK) ?
                          (rotated & wr.bit_mask) : wr.bit_mask;

    // ------------
    // per-plane source, logic operation and bit mask
    // ------------
    for (genvar p = 0; p < 4; p++) begin : g_plane
        wire [7:0] lat = wr.latch[p*8 +: 8];
        wire [7:0] src = (wr.write_mode == WM_FILL) ? {8{wr.host_data[p]}} :
                         (wr.write_mode == WM_SR_MASK) ? {8{wr.set_reset[p]}} :
                         wr.sr_enable[p] ? {8{wr.set_reset[p]}} :
                         rotated;
        wire [7:0] op_out = alu(wr.logic_op, src, lat);
        wire [7:0] merged = (op_out & eff_mask) | (lat & ~eff_mask);
        assign wr.plane_data[p*8 +: 8] = (wr.write_mode == WM_LATCH) ? lat : merged;
    end

endmodule

// ==== hw/pgd_datapath.sv ====
// Purpose: host graphics datapath between host memory cycles and 4 planes
// Assumes: host strobes are one-cycle pulses synchronous to clk_in
// Notes:   one memory request at a time; host_ready_out shows when taken
//
// Notes on behaviour
// - op field: pass, and, or, xor
// - rotate first, then the logic operation
// - mode 0 rotates host byte right 0-7
// - plane selector picks plane for reads
// - read type: selected plane or compare
// - participation bit zero means always matching
// - selector ignored during compare reads
// - 256-colour bit overrides interleave shift loading
// - interleave splits odd and even bits
// - odd/even bit enables odd/even addressing
// - mode 0: rotated byte or set/reset fill
// - mode 1 writes latches; reads reload latches
// - mode 2: host bit n fills plane n
// - mode 3: set/reset fill, rotated masked
// - logic operation applies in modes 0,2,3
// - mask zero keeps latched bit everywhere
// - window field decodes four host windows
// - chain bit replaces address bit zero
// - graphics bit disables character latches
// - index port selects data port register
// - set/reset bit fills its plane
// - non-enabled planes take host data
// - compare returns ones where planes match
`timescale 1ns/100ps
module pgd_datapath
    import pgd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic io_data_sel_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    input wire logic mem_wr_in,
    input wire logic mem_rd_in,
    input wire logic [19:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    output logic host_ready_out,
    output logic [7:0] host_rdata_out,
    output logic host_rvalid_out,
    input wire logic [3:0] map_mask_in,
    input wire logic chain4_in,
    output logic [15:0] plane_addr_out,
    output logic [3:0] plane_we_out,
    output logic plane_rd_out,
    output logic [31:0] plane_wdata_out,
    input wire logic [31:0] plane_rdata_in,
    input wire logic disp_load_in,
    input wire logic [31:0] disp_data_in,
    output logic [31:0] disp_shift_out,
    output logic graphics_addr_out,
    output logic char_latch_en_out,
    output logic odd_even_out
);
    // ------------
    // helper functions
    // ------------
    // window decode: returns {hit, 17-bit offset}
    function automatic logic [17:0] win_decode(input logic [1:0] sel, input logic [19:0] a);
        case (sel)
            2'h0: return {a[19:17] == WIN_128K_TAG, a[16:0]};
            2'h1: return {a[19:16] == WIN_64K_TAG, 1'b0, a[15:0]};
            2'h2: return {a[19:15] == WIN_B0_TAG, 2'b00, a[14:0]};
            default: return {a[19:15] == WIN_B8_TAG, 2'b00, a[14:0]};
        endcase
    endfunction
    // pick byte of one plane out of a 32-bit plane word
    function automatic logic [7:0] plane_byte(input logic [31:0] w, input logic [1:0] p);
        return w[{p, 3'b000} +: 8];
    endfunction
    // ------------
    // registers
    // ------------
    logic [3:0] index_q;
    logic [3:0] set_reset_q;
    logic [3:0] sr_enable_q;
    logic [3:0] color_cmp_q;
    logic [4:0] rotate_op_q;
    logic [1:0] read_sel_q;
    logic [6:0] access_mode_q;
    logic [3:0] window_ctl_q;
    logic [3:0] participate_q;
    logic [7:0] bit_mask_q;
    logic [7:0] io_rdata_q;
    logic [31:0] latch_q;
    pgd_state_t state_q;
    pgd_state_t state_d;
    logic [15:0] plane_addr_q;
    logic [3:0] plane_we_q;
    logic [31:0] plane_wdata_q;
    logic [1:0] rd_plane_q;
    logic rd_cmp_q;
    logic [7:0] host_rdata_q;
    logic host_rvalid_q;
    logic [31:0] disp_shift_q;
    logic ready_q;
    logic plane_rd_q;
    logic char_latch_q;
    // ------------
    // mode field decode
    // ------------
    wire [1:0] write_mode = access_mode_q[MODE_WR_LSB +: 2];
    wire read_cmp = access_mode_q[MODE_READ_TYPE];
    wire odd_even = access_mode_q[MODE_ODD_EVEN];
    wire interleave = access_mode_q[MODE_INTERLEAVE];
    wire mode_256 = access_mode_q[MODE_256];
    wire [1:0] win_sel = window_ctl_q[WIN_SEL_LSB +: 2];
    wire chain = window_ctl_q[WIN_CHAIN];
    // ------------
    // register port write decode
    // ------------
    wire idx_wr = io_wr_in & ~io_data_sel_in;
    wire dat_wr = io_wr_in & io_data_sel_in;

    // index register selects the data port target
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            index_q <= RST_ZERO[3:0];
        end else if (idx_wr) begin
            index_q <= io_wdata_in[3:0];
        end
    end

    // data port writes into the indexed register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            set_reset_q <= RST_ZERO[3:0];
            sr_enable_q <= RST_ZERO[3:0];
            color_cmp_q <= RST_ZERO[3:0];
            rotate_op_q <= RST_ZERO[4:0];
            read_sel_q <= RST_ZERO[1:0];
            access_mode_q <= RST_ZERO[6:0];
            window_ctl_q <= RST_ZERO[3:0];
            participate_q <= RST_PARTICIPATE[3:0];
            bit_mask_q <= RST_BIT_MASK;
        end else if (dat_wr) begin
            case (index_q)
                IDX_SET_RESET: set_reset_q <= io_wdata_in[3:0];
                IDX_SR_ENABLE: sr_enable_q <= io_wdata_in[3:0];
                IDX_COLOR_CMP: color_cmp_q <= io_wdata_in[3:0];
                IDX_ROTATE_OP: rotate_op_q <= io_wdata_in[4:0];
                IDX_READ_SEL: read_sel_q <= io_wdata_in[1:0];
                IDX_ACCESS_MODE: access_mode_q <= {io_wdata_in[6:3], 1'b0, io_wdata_in[1:0]};
                IDX_WINDOW_CTL: window_ctl_q <= io_wdata_in[3:0];
                IDX_PARTICIPATE: participate_q <= io_wdata_in[3:0];
                IDX_BIT_MASK: bit_mask_q <= io_wdata_in;
                default: ;
            endcase
        end
    end
    // ------------
    // register port read mux, reserved bits read as zero
    // ------------
    logic [7:0] reg_rd_mux;
    always_comb begin
        case (index_q)
            IDX_SET_RESET: reg_rd_mux = {4'h0, set_reset_q};
            IDX_SR_ENABLE: reg_rd_mux = {4'h0, sr_enable_q};
            IDX_COLOR_CMP: reg_rd_mux = {4'h0, color_cmp_q};
            IDX_ROTATE_OP: reg_rd_mux = {3'h0, rotate_op_q};
            IDX_READ_SEL: reg_rd_mux = {6'h00, read_sel_q};
            IDX_ACCESS_MODE: reg_rd_mux = {1'b0, access_mode_q};
            IDX_WINDOW_CTL: reg_rd_mux = {4'h0, window_ctl_q};
            IDX_PARTICIPATE: reg_rd_mux = {4'h0, participate_q};
            IDX_BIT_MASK: reg_rd_mux = bit_mask_q;
            default: reg_rd_mux = 8'h00;
        endcase
    end

    // read answer is registered one cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_rdata_q <= 8'h00;
        end else if (io_rd_in) begin
            io_rdata_q <= io_data_sel_in ? reg_rd_mux : {4'h0, index_q};
        end
    end
    // ------------
    // host memory window and plane addressing
    // ------------
    wire [17:0] win_res = win_decode(win_sel, host_addr_in);
    wire win_hit = win_res[17];
    wire [16:0] win_off = win_res[16:0];
    wire idle = (state_q == ST_IDLE);
    wire take_wr = idle & mem_wr_in & win_hit;
    wire take_rd = idle & mem_rd_in & ~mem_wr_in & win_hit;

    // chain substitutes a high offset bit for bit 0; host A0 picks odd/even
    wire [15:0] chain_addr = {win_off[15:1], win_off[16]};
    wire [15:0] c4_addr = {2'b00, win_off[15:2]};
    wire [15:0] mem_addr = chain4_in ? c4_addr : chain ? chain_addr : win_off[15:0];
    // planes enabled for a write in each addressing scheme
    wire [3:0] c4_planes = 4'h1 << win_off[1:0];
    wire [3:0] oe_planes = win_off[0] ? 4'ha : 4'h5;
    wire [3:0] wr_planes = map_mask_in & (chain4_in ? c4_planes :
                           odd_even ? oe_planes : 4'hf);
    // plane chosen for a plane read
    wire [1:0] rd_plane = chain4_in ? win_off[1:0] :
                          odd_even ? {read_sel_q[1], win_off[0]} :
                          read_sel_q;
    // ------------
    // write datapath
    // ------------
    pgd_wr_if wr_bus();
    assign wr_bus.set_reset = set_reset_q;
    assign wr_bus.sr_enable = sr_enable_q;
    assign wr_bus.rot_cnt = rotate_op_q[ROT_CNT_LSB +: 3];
    assign wr_bus.logic_op = rotate_op_q[ROT_OP_LSB +: 2];
    assign wr_bus.write_mode = write_mode;
    assign wr_bus.bit_mask = bit_mask_q;
    assign wr_bus.host_data = host_wdata_in;
    assign wr_bus.latch = latch_q;
    pgd_write_path u_write_path (
        .wr(wr_bus)
    );
    // ------------
    // memory cycle sequencer
    // ------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take_rd) begin
                    state_d = ST_RD_ISSUE;
                end
            end
            ST_RD_ISSUE: state_d = ST_RD_CAPTURE;
            ST_RD_CAPTURE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            plane_rd_q <= 1'b0;
            char_latch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == ST_IDLE);
            plane_rd_q <= (state_d == ST_RD_ISSUE);
            char_latch_q <= ~window_ctl_q[WIN_GRAPHICS];
        end
    end

    // plane address, strobes and write data for one cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            plane_addr_q <= 16'h0000;
            plane_we_q <= 4'h0;
            plane_wdata_q <= 32'h0000_0000;
        end else begin
            plane_we_q <= take_wr ? wr_planes : 4'h0;
            if (take_wr || take_rd) begin
                plane_addr_q <= mem_addr;
            end
            if (take_wr) begin
                plane_wdata_q <= wr_bus.plane_data;
            end
        end
    end

    // read context captured when the read is taken
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_plane_q <= 2'h0;
            rd_cmp_q <= 1'b0;
        end else if (take_rd) begin
            rd_plane_q <= rd_plane;
            rd_cmp_q <= read_cmp;
        end
    end
    // ------------
    // read return path and colour compare
    // ------------
    logic [7:0] cmp_bits;
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            cmp_bits[b] = 1'b1;
            for (int p = 0; p < 4; p++) begin
                if (participate_q[p] && (plane_rdata_in[p*8 + b] != color_cmp_q[p])) begin
                    cmp_bits[b] = 1'b0;
                end
            end
        end
    end
    wire capture = (state_q == ST_RD_CAPTURE);
    wire [7:0] rd_result = rd_cmp_q ? cmp_bits :
                           plane_byte(plane_rdata_in, rd_plane_q);
    // every memory read reloads all four latches
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            latch_q <= 32'h0000_0000;
        end else if (capture) begin
            latch_q <= plane_rdata_in;
        end
    end

    // host read answer
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            host_rdata_q <= 8'h00;
            host_rvalid_q <= 1'b0;
        end else begin
            host_rvalid_q <= capture;
            if (capture) begin
                host_rdata_q <= rd_result;
            end
        end
    end
    // ------------
    // display shift register loading
    // ------------
    logic [31:0] disp_fmt;
    always_comb begin
        disp_fmt = disp_data_in;
        if (!mode_256 && interleave) begin
            for (int k = 0; k < 2; k++) begin
                for (int j = 0; j < 4; j++) begin
                    // even plane takes even bits of the pair, odd plane the odd bits
                    disp_fmt[k*16 + 4 + j] = disp_data_in[k*16 + 2*j];
                    disp_fmt[k*16 + j] = disp_data_in[k*16 + 8 + 2*j];
                    disp_fmt[k*16 + 12 + j] = disp_data_in[k*16 + 2*j + 1];
                    disp_fmt[k*16 + 8 + j] = disp_data_in[k*16 + 8 + 2*j + 1];
                end
            end
        end
    end

    // shift register load
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            disp_shift_q <= 32'h0000_0000;
        end else if (disp_load_in) begin
            disp_shift_q <= disp_fmt;
        end
    end
    // ------------
    // outputs
    // ------------
    assign io_rdata_out = io_rdata_q;
    assign host_ready_out = ready_q;
    assign host_rdata_out = host_rdata_q;
    assign host_rvalid_out = host_rvalid_q;
    assign plane_addr_out = plane_addr_q;
    assign plane_we_out = plane_we_q;
    assign plane_rd_out = plane_rd_q;
    assign plane_wdata_out = plane_wdata_q;
    assign disp_shift_out = disp_shift_q;
    assign graphics_addr_out = window_ctl_q[WIN_GRAPHICS];
    assign char_latch_en_out = char_latch_q;
    assign odd_even_out = odd_even;

endmodule

// ==== test/pgd_datapath_assertions.sv ====
// Purpose: port-level checks of the planar graphics datapath
// Assumes: one clock domain, reset low disables every check
// Notes: bound to the datapath top from the bench file
`timescale 1ns/100ps
module pgd_datapath_checker (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic mem_wr_in,
    input wire logic host_ready_out,
    input wire logic host_rvalid_out,
    input wire logic [7:0] host_rdata_out,
    input wire logic [3:0] plane_we_out,
    input wire logic plane_rd_out,
    input wire logic graphics_addr_out,
    input wire logic char_latch_en_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // plane strobes, read answers and character latches tied to their causes
    chk_we_cause: assert property (plane_we_out != 4'h0 |-> $past(mem_wr_in))
        else $error("plane write without host write");
    chk_we_pulse: assert property (plane_we_out != 4'h0 && !mem_wr_in |=> !plane_we_out)
        else $error("plane write strobe too long");
    chk_rd_busy: assert property (plane_rd_out |-> !host_ready_out ##1 !host_ready_out
        ##1 (host_ready_out && host_rvalid_out)) else $error("read cycle timing wrong");
    chk_rvalid_cause: assert property (host_rvalid_out |-> $past(plane_rd_out, 2))
        else $error("read answer without plane read");
    chk_rvalid_pulse: assert property (host_rvalid_out |=> !host_rvalid_out)
        else $error("read valid longer than one cycle");
    chk_rdata_hold: assert property (!host_rvalid_out |-> $stable(host_rdata_out))
        else $error("read data moved without valid");
    chk_busy_ignore: assert property (!host_ready_out |=> !plane_we_out && !plane_rd_out)
        else $error("request taken while busy");
    chk_char_latch: assert property (graphics_addr_out && $past(graphics_addr_out)
        |-> !char_latch_en_out) else $error("character latches on in graphics");
    // main traffic kinds
    cov_read: cover property (host_rvalid_out);
    cov_write: cover property (plane_we_out == 4'hf);
    cov_graphics: cover property (graphics_addr_out);
endmodule

// ==== test/pgd_plane_model.sv ====
// Purpose: four display planes behind the datapath plane port
// Assumes: sixteen words, picked by the low address bits
// Notes: read word is valid only in the cycle after the strobe
`timescale 1ns/100ps
module pgd_plane_model (
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic [3:0] we_in,
    input wire logic rd_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);
    logic [31:0] mem_q [16] = '{default: 32'h0};
    logic [31:0] word_q = 32'h0;
    logic rd_q = 1'b0;
    // byte lanes written side by side, read word captured on the strobe
    always @(posedge clk_in) begin
        for (int p = 0; p < 4; p++)
            if (we_in[p]) mem_q[addr_in[3:0]][p*8+:8] <= wdata_in[p*8+:8];
        rd_q <= rd_in;
        if (rd_in) word_q <= mem_q[addr_in[3:0]];
    end
    // outside the answer cycle the bus carries the inverted word
    assign rdata_out = rd_q ? word_q : ~word_q;
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the planar graphics datapath
// Assumes: plane model on the plane port, sequencer inputs held
// Notes: expected plane bytes are worked out by hand per scenario
`timescale 1ns/100ps
module tb_top;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic io_wr_in = 1'b0, io_rd_in = 1'b0, io_data_sel_in = 1'b0;
    logic mem_wr_in = 1'b0, mem_rd_in = 1'b0, disp_load_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00, host_wdata_in = 8'h00, io_rdata_out, host_rdata_out;
    logic [19:0] host_addr_in = 20'ha0000;
    logic host_ready_out, host_rvalid_out, plane_rd_out, graphics_addr_out;
    logic char_latch_en_out, odd_even_out;
    logic [15:0] plane_addr_out;
    logic [3:0] plane_we_out;
    logic [31:0] plane_wdata_out, plane_rdata_in, disp_shift_out;
    int fails = 0;
    int samples_checked = 0;
    pgd_datapath DUT (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
        .io_data_sel_in(io_data_sel_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
        .mem_wr_in(mem_wr_in), .mem_rd_in(mem_rd_in), .host_addr_in(host_addr_in),
        .host_wdata_in(host_wdata_in), .host_ready_out(host_ready_out),
        .host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
        .map_mask_in(4'hf), .chain4_in(1'b0), .plane_addr_out(plane_addr_out),
        .plane_we_out(plane_we_out), .plane_rd_out(plane_rd_out),
        .plane_wdata_out(plane_wdata_out), .plane_rdata_in(plane_rdata_in),
        .disp_load_in(disp_load_in), .disp_data_in(32'haa55), .disp_shift_out(disp_shift_out),
        .graphics_addr_out(graphics_addr_out), .char_latch_en_out(char_latch_en_out),
        .odd_even_out(odd_even_out));
    pgd_plane_model u_planes (.clk_in(clk_in), .addr_in(plane_addr_out), .we_in(plane_we_out),
        .rd_in(plane_rd_out), .wdata_in(plane_wdata_out), .rdata_out(plane_rdata_in));
    always #10 clk_in = ~clk_in;
    task automatic close_out;
        $display("compared %0d mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one register port strobe, then the settled read data
    task automatic io_cyc(logic wr, logic sel, logic [7:0] v);
        @(posedge clk_in);
        io_wr_in <= wr;
        io_rd_in <= !wr;
        io_data_sel_in <= sel;
        io_wdata_in <= v;
        @(posedge clk_in);
        io_wr_in <= 1'b0;
        io_rd_in <= 1'b0;
        #1;
    endtask
    task automatic wr_reg(logic [7:0] i, logic [7:0] v);
        io_cyc(1'b1, 1'b0, i);
        io_cyc(1'b1, 1'b1, v);
    endtask
    task automatic reg_chk(logic [7:0] i, logic [7:0] exp);
        io_cyc(1'b1, 1'b0, i);
        io_cyc(1'b0, 1'b1, 8'h00);
        chk("reg", io_rdata_out, exp);
    endtask
    // one host memory request, waiting for the read answer if any
    task automatic mem_op(logic wr, logic [19:0] a, logic [7:0] d);
        @(posedge clk_in);
        mem_wr_in <= wr;
        mem_rd_in <= !wr;
        host_addr_in <= a;
        host_wdata_in <= d;
        @(posedge clk_in);
        mem_wr_in <= 1'b0;
        mem_rd_in <= 1'b0;
        #1;
        for (int n = 0; n < 4 && !wr && host_rvalid_out !== 1'b1; n++) @(posedge clk_in) #1;
    endtask
    task automatic t_ops;
        logic [7:0] op_exp [4] = '{8'h78, 8'h58, 8'h7a, 8'h22};
        reg_chk(8'h08, 8'hff);
        reg_chk(8'h07, 8'h0f);
        reg_chk(8'h03, 8'h00);
        mem_op(1'b1, 20'ha0000, 8'h5a);
        chk("we", plane_we_out, 4'hf);
        mem_op(1'b0, 20'ha0000, 8'h00);
        chk("rd", host_rdata_out, 8'h5a);
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h03, 8'(k * 8 + 3));
            mem_op(1'b1, 20'ha0000, 8'hc3);
            chk("op", plane_wdata_out, {4{op_exp[k]}});
        end
        wr_reg(8'h03, 8'h00);
    endtask
    task automatic t_sr;
        wr_reg(8'h00, 8'h05);
        wr_reg(8'h01, 8'h03);
        mem_op(1'b1, 20'ha0001, 8'h3c);
        chk("sr", plane_wdata_out, 32'h3c3c00ff);
        wr_reg(8'h01, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'h04, 8'(s));
            mem_op(1'b0, 20'ha0001, 8'h00);
            chk("sel", host_rdata_out, (32'h3c3c00ff >> (8 * s)) & 32'hff);
        end
        wr_reg(8'h05, 8'h08);
        wr_reg(8'h02, 8'h0d);
        mem_op(1'b0, 20'ha0001, 8'h00);
        chk("cmp", host_rdata_out, 8'h3c);
        wr_reg(8'h07, 8'h03);
        mem_op(1'b0, 20'ha0001, 8'h00);
        chk("care", host_rdata_out, 8'hff);
        wr_reg(8'h07, 8'h0f);
    endtask
    task automatic t_modes;
        wr_reg(8'h05, 8'h01);
        mem_op(1'b1, 20'ha0002, 8'h99);
        chk("m1", plane_wdata_out, 32'h3c3c00ff);
        wr_reg(8'h05, 8'h02);
        wr_reg(8'h08, 8'h0f);
        mem_op(1'b1, 20'ha0002, 8'ha5);
        chk("m2", plane_wdata_out, 32'h303f00ff);
        wr_reg(8'h05, 8'h03);
        wr_reg(8'h08, 8'hff);
        wr_reg(8'h00, 8'h09);
        mem_op(1'b1, 20'ha0002, 8'hf0);
        chk("m3", plane_wdata_out, 32'hfc0c00ff);
        wr_reg(8'h03, 8'h18);
        mem_op(1'b1, 20'ha0002, 8'hf0);
        chk("m3x", plane_wdata_out, 32'hcc3c000f);
        wr_reg(8'h03, 8'h00);
        wr_reg(8'h05, 8'h10);
        chk("oe", odd_even_out, 1'b1);
        mem_op(1'b1, 20'ha0001, 8'h00);
        chk("oewe", plane_we_out, 4'ha);
        wr_reg(8'h05, 8'h00);
    endtask
    task automatic t_win;
        logic [19:0] w_in [4] = '{20'ha0000, 20'ha0000, 20'hb0000, 20'hb8000};
        logic [19:0] w_out [4] = '{20'hc0000, 20'hb0000, 20'hb8000, 20'hb0000};
        for (int w = 0; w < 4; w++) begin
            wr_reg(8'h06, 8'(w * 4 + 1));
            mem_op(1'b1, w_in[w], 8'h00);
            chk("win", plane_we_out, 4'hf);
            mem_op(1'b1, w_out[w], 8'h00);
            chk("wout", plane_we_out, 4'h0);
        end
        chk("gfx", {graphics_addr_out, char_latch_en_out}, 2'b10);
    endtask
    task automatic t_disp;
        for (int m = 0; m < 2; m++) begin
            wr_reg(8'h05, 8'(m * 64 + 32));
            @(posedge clk_in) disp_load_in <= 1'b1;
            @(posedge clk_in) disp_load_in <= 1'b0;
            #1 chk("disp", disp_shift_out, m ? 32'haa55 : 32'h0ff0);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_ops;
        t_sr;
        t_modes;
        t_win;
        t_disp;
        close_out;
    end
    initial begin
        #100000;
        fails++;
        close_out;
    end
endmodule
bind pgd_datapath pgd_datapath_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .mem_wr_in(mem_wr_in), .host_ready_out(host_ready_out), .host_rvalid_out(host_rvalid_out),
    .host_rdata_out(host_rdata_out), .plane_we_out(plane_we_out), .plane_rd_out(plane_rd_out),
    .graphics_addr_out(graphics_addr_out), .char_latch_en_out(char_latch_en_out));
